// ### inc/power_mode_pkg.sv
/*
 * Constants, register map and mode encoding of the operating-mode controller.
 * Assumes a 250 MHz sys_clk and an APB master with 32-bit data.
 */
// Summary of operation
// - In not-powered and power-off modes the application interfaces stay disabled.
// - From active, a shutdown command or a power pin action sends the device to power-off.
// - From power-off only a power pin action switches the device on to active.
// - In deep sleep only the real-time clock runs; radio and interfaces are off.
// - With power saving enabled, expiry of the active timer sends active to deep sleep.
// - With the sleep policy enabled, 6 s without host activity sends active to deep sleep.
// - With extended sleep enabled, a gap between paging cycles sends active to deep sleep.
// - On positioning variants, ongoing positioning activity blocks every automatic sleep entry.
// - In deep sleep, expiry of the periodic tracking area update timer wakes the device.
// - In deep sleep under extended sleep, the paging wake time wakes the device.
// - In deep sleep, a power pin action wakes the device to active.
package power_mode_pkg;
    // Modes, Gray along not-powered, power-off, active, deep sleep
    typedef enum logic [1:0] {
        NOT_POWERED = 2'h0,
        POWER_OFF = 2'h1,
        ACTIVE = 2'h3,
        DEEP_SLEEP = 2'h2
    } mode_e;

    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int RTC_TICK_NS = 1000000;
    localparam int RTC_TICK_CYCLES_DFLT = RTC_TICK_NS / CLK_PERIOD_NS;
    localparam int INACT_TIME_S = 6;
    localparam logic [31:0] INACT_TICKS = 32'(64'(INACT_TIME_S) * 64'd1000000000 / 64'(RTC_TICK_NS));
    localparam int TICK_W = 18;

    // Timers
    localparam int TIMER_W = 32;
    localparam int NUM_TIMERS = 4;
    localparam int T_ACT = 0;
    localparam int T_TAU = 1;
    localparam int T_INACT = 2;
    localparam int T_EDRX = 3;

    // APB register map
    localparam int APB_AW = 8;
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] CMD_ADDR = 8'h04;
    localparam logic [7:0] T3324_ADDR = 8'h08;
    localparam logic [7:0] T3412_ADDR = 8'h0C;
    localparam logic [7:0] EDRX_ADDR = 8'h10;
    localparam logic [7:0] STATUS_ADDR = 8'h14;

    // Control fields
    localparam int CTRL_W = 4;
    localparam int CTRL_PSM_BIT = 0;
    localparam int CTRL_INACT_BIT = 1;
    localparam int CTRL_EDRX_BIT = 2;
    localparam int CTRL_GNSS_BIT = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;

    // Command fields
    localparam int CMD_SHUTDOWN_BIT = 0;
    localparam int CMD_ACTIVITY_BIT = 1;

    // Status fields
    localparam int STAT_IF_BIT = 4;
    localparam int STAT_RADIO_BIT = 5;
    localparam int STAT_RTC_BIT = 6;

    // Reset values
    localparam logic [31:0] TIMER_RST = 32'h0000_0000;
    localparam logic [31:0] TIMER_ONE = 32'h0000_0001;
endpackage : power_mode_pkg

// ### logic/tick_timer.sv
/*
 * Loadable down counter stepped by the real-time clock tick.
 * Assumes load and tick are one-cycle pulses on sys_clk; a reload of zero never expires.
 */
`timescale 1ns/1ns
`default_nettype none
module tick_timer
    import power_mode_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Control
    input wire logic load,
    input wire logic [TIMER_W-1:0] reloadValue,
    input wire logic run,
    input wire logic tick,
    // Status
    output logic done
);
    logic [TIMER_W-1:0] countQ;
    logic doneQ;

    // Count down on ticks, flag expiry until the next load
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            countQ <= TIMER_RST;
            doneQ <= 1'b0;
        end else if (load) begin
            countQ <= reloadValue;
            doneQ <= 1'b0;
        end else if (run && tick && countQ != TIMER_RST) begin
            countQ <= countQ - TIMER_ONE;
            if (countQ == TIMER_ONE) begin
                doneQ <= 1'b1;
            end
        end
    end

    assign done = doneQ;
endmodule : tick_timer
`default_nettype wire

// ### logic/power_mode_ctrl.sv
/*
 * Operating-mode controller: not-powered, power-off, active and deep sleep, with APB registers.
 * Assumes all pin inputs are synchronous to sys_clk and hostActivity, edrxGapStart are pulses.
 */
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module power_mode_ctrl
    import power_mode_pkg::*;
#(
    parameter int RTC_TICK_CYCLES = RTC_TICK_CYCLES_DFLT
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Supply and host pins
    input wire logic supplyOk,
    input wire logic powerSwitchInput,
    input wire logic powerControlInput,
    input wire logic hostActivity,
    // Radio side events
    input wire logic gnssBusy,
    input wire logic edrxGapStart,
    // Mode outputs
    output logic [1:0] modeOut,
    output logic ifEnable,
    output logic radioEnable,
    output logic rtcRun
);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(RTC_TICK_CYCLES - 1);

    mode_e modeQ;
    mode_e modeD;
    logic [CTRL_W-1:0] ctrlQ;
    logic [TIMER_W-1:0] t3324Q;
    logic [TIMER_W-1:0] t3412Q;
    logic [TIMER_W-1:0] edrxQ;
    logic shutdownCmdQ;
    logic activityCmdQ;
    logic pinPrevQ;
    logic [TICK_W-1:0] tickCntQ;
    logic tickQ;
    logic ifEnableQ;
    logic radioEnableQ;
    logic rtcRunQ;
    logic [31:0] prdataQ;
    logic preadyQ;
    logic pslverrQ;
    logic [31:0] readMux;
    logic addrHit;
    logic setupPh;
    logic wrEn;
    logic pinEvent;
    logic gnssBlock;
    logic sleepReq;
    logic enterActive;
    logic enterSleep;
    logic [NUM_TIMERS-1:0] loadVec;
    logic [NUM_TIMERS-1:0] runVec;
    logic [NUM_TIMERS-1:0] doneVec;
    logic [TIMER_W-1:0] reloadVal [NUM_TIMERS];
    logic anyEvent;

    // APB decode
    assign setupPh = psel && !penable;
    assign wrEn = psel && penable && preadyQ && pwrite && addrHit;

    always_comb begin
        addrHit = 1'b1;
        readMux = 32'h0000_0000;
        case (paddr)
            CTRL_ADDR: begin
                readMux[CTRL_W-1:0] = ctrlQ;
            end
            CMD_ADDR: begin
                readMux = 32'h0000_0000;
            end
            T3324_ADDR: begin
                readMux = t3324Q;
            end
            T3412_ADDR: begin
                readMux = t3412Q;
            end
            EDRX_ADDR: begin
                readMux = edrxQ;
            end
            STATUS_ADDR: begin
                readMux[1:0] = modeQ;
                readMux[STAT_IF_BIT] = ifEnableQ;
                readMux[STAT_RADIO_BIT] = radioEnableQ;
                readMux[STAT_RTC_BIT] = rtcRunQ;
            end
            default: begin
                addrHit = 1'b0;
            end
        endcase
    end

    // One wait-free access phase, data and error latched at setup
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            preadyQ <= 1'b0;
            prdataQ <= 32'h0000_0000;
            pslverrQ <= 1'b0;
        end else begin
            preadyQ <= setupPh;
            prdataQ <= setupPh && !pwrite ? readMux : 32'h0000_0000;
            pslverrQ <= setupPh && !addrHit;
        end
    end

    // Configuration registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrlQ <= CTRL_RST;
            t3324Q <= TIMER_RST;
            t3412Q <= TIMER_RST;
            edrxQ <= TIMER_RST;
        end else if (wrEn) begin
            case (paddr)
                CTRL_ADDR: begin
                    ctrlQ <= pwdata[CTRL_W-1:0];
                end
                T3324_ADDR: begin
                    t3324Q <= pwdata;
                end
                T3412_ADDR: begin
                    t3412Q <= pwdata;
                end
                EDRX_ADDR: begin
                    edrxQ <= pwdata;
                end
                default: begin
                    ctrlQ <= ctrlQ;
                end
            endcase
        end
    end

    // Command strobes, one cycle each
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            shutdownCmdQ <= 1'b0;
            activityCmdQ <= 1'b0;
        end else begin
            shutdownCmdQ <= wrEn && paddr == CMD_ADDR && pwdata[CMD_SHUTDOWN_BIT];
            activityCmdQ <= wrEn && paddr == CMD_ADDR && pwdata[CMD_ACTIVITY_BIT];
        end
    end

    // Power pin edge
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pinPrevQ <= 1'b0;
        end else begin
            pinPrevQ <= powerSwitchInput || powerControlInput;
        end
    end
    assign pinEvent = (powerSwitchInput || powerControlInput) && !pinPrevQ;

    // Real-time clock tick, runs in every mode except not-powered
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            tickCntQ <= '0;
            tickQ <= 1'b0;
        end else if (modeQ == NOT_POWERED) begin
            tickCntQ <= '0;
            tickQ <= 1'b0;
        end else begin
            tickQ <= tickCntQ == TICK_LAST;
            tickCntQ <= tickCntQ == TICK_LAST ? '0 : tickCntQ + 1'b1;
        end
    end

    // Sleep entry conditions
    assign gnssBlock = ctrlQ[CTRL_GNSS_BIT] && gnssBusy;
    assign sleepReq = !gnssBlock && ((ctrlQ[CTRL_PSM_BIT] && doneVec[T_ACT])
        || (ctrlQ[CTRL_INACT_BIT] && doneVec[T_INACT])
        || (ctrlQ[CTRL_EDRX_BIT] && edrxGapStart));

    // Mode transitions
    always_comb begin
        modeD = modeQ;
        case (modeQ)
            NOT_POWERED: begin
                if (supplyOk) begin
                    modeD = POWER_OFF;
                end
            end
            POWER_OFF: begin
                if (!supplyOk) begin
                    modeD = NOT_POWERED;
                end else if (pinEvent) begin
                    modeD = ACTIVE;
                end
            end
            ACTIVE: begin
                if (!supplyOk) begin
                    modeD = NOT_POWERED;
                end else if (pinEvent || shutdownCmdQ) begin
                    modeD = POWER_OFF;
                end else if (sleepReq) begin
                    modeD = DEEP_SLEEP;
                end
            end
            DEEP_SLEEP: begin
                if (!supplyOk) begin
                    modeD = NOT_POWERED;
                end else if (pinEvent) begin
                    modeD = ACTIVE;
                end else if (doneVec[T_TAU]) begin
                    modeD = ACTIVE;
                end else if (ctrlQ[CTRL_EDRX_BIT] && doneVec[T_EDRX]) begin
                    modeD = ACTIVE;
                end
            end
            default: begin
                modeD = NOT_POWERED;
            end
        endcase
    end

    // Mode register, one mode at a time
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            modeQ <= NOT_POWERED;
        end else begin
            modeQ <= modeD;
        end
    end

    // Interfaces, radio and clock enables follow the mode
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ifEnableQ <= 1'b0;
            radioEnableQ <= 1'b0;
            rtcRunQ <= 1'b0;
        end else begin
            ifEnableQ <= modeD == ACTIVE;
            radioEnableQ <= modeD == ACTIVE;
            rtcRunQ <= modeD != NOT_POWERED;
        end
    end

    // Timer loads and run windows
    assign enterActive = modeQ != ACTIVE && modeD == ACTIVE;
    assign enterSleep = modeQ != DEEP_SLEEP && modeD == DEEP_SLEEP;
    assign reloadVal[T_ACT] = t3324Q;
    assign reloadVal[T_TAU] = t3412Q;
    assign reloadVal[T_INACT] = INACT_TICKS;
    assign reloadVal[T_EDRX] = edrxQ;
    assign loadVec[T_ACT] = enterActive;
    assign loadVec[T_TAU] = enterActive || (modeQ == ACTIVE && doneVec[T_TAU]);
    assign loadVec[T_INACT] = enterActive || hostActivity || activityCmdQ;
    assign loadVec[T_EDRX] = enterSleep;
    assign runVec[T_ACT] = modeQ == ACTIVE;
    assign runVec[T_TAU] = modeQ == ACTIVE || modeQ == DEEP_SLEEP;
    assign runVec[T_INACT] = modeQ == ACTIVE;
    assign runVec[T_EDRX] = modeQ == DEEP_SLEEP;

    generate
        for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
            tick_timer u_timer (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .load(loadVec[i]),
                .reloadValue(reloadVal[i]),
                .run(runVec[i]),
                .tick(tickQ),
                .done(doneVec[i])
            );
        end
    endgenerate

    // Outputs
    assign prdata = prdataQ;
    assign pready = preadyQ;
    assign pslverr = pslverrQ;
    assign modeOut = modeQ;
    assign ifEnable = ifEnableQ;
    assign radioEnable = radioEnableQ;
    assign rtcRun = rtcRunQ;

    // Checks
    assign anyEvent = (supplyOk != (modeQ != NOT_POWERED)) || pinEvent || shutdownCmdQ || sleepReq
        || doneVec[T_TAU] || doneVec[T_EDRX];

    ifaces_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (modeQ == NOT_POWERED || modeQ == POWER_OFF) |-> !ifEnableQ && !radioEnableQ)
        else $error("interfaces enabled while switched off");

    shutdown_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        modeQ == ACTIVE && supplyOk && shutdownCmdQ |=> modeQ == POWER_OFF && !ifEnableQ)
        else $error("shutdown command did not reach power-off");

    switch_on_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        modeQ == POWER_OFF && supplyOk |=> (modeQ == ACTIVE) == $past(pinEvent))
        else $error("power-off left without or ignored a pin event");

    sleep_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        modeQ == DEEP_SLEEP |-> !radioEnableQ && !ifEnableQ && rtcRunQ)
        else $error("deep sleep with radio or interfaces on");

    psm_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        modeQ == ACTIVE && supplyOk && !pinEvent && !shutdownCmdQ && !gnssBlock
        && ctrlQ[CTRL_PSM_BIT] && doneVec[T_ACT] |=> modeQ == DEEP_SLEEP)
        else $error("active timer expiry did not enter deep sleep");

    inact_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        modeQ == ACTIVE && supplyOk && !pinEvent && !shutdownCmdQ && !gnssBlock
        && ctrlQ[CTRL_INACT_BIT] && doneVec[T_INACT] |=> modeQ == DEEP_SLEEP)
        else $error("inactivity expiry did not enter deep sleep");

    edrx_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        modeQ == ACTIVE && supplyOk && !pinEvent && !shutdownCmdQ && !gnssBlock
        && ctrlQ[CTRL_EDRX_BIT] && edrxGapStart |=> modeQ == DEEP_SLEEP && !radioEnableQ)
        else $error("paging gap did not enter deep sleep");

    gnss_block_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        modeQ == ACTIVE && gnssBlock |=> modeQ != DEEP_SLEEP)
        else $error("deep sleep entered during positioning");

    tau_wake_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        modeQ == DEEP_SLEEP && supplyOk && doneVec[T_TAU] |=> modeQ == ACTIVE && ifEnableQ)
        else $error("update timer did not wake the device");

    edrx_wake_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        modeQ == DEEP_SLEEP && supplyOk && ctrlQ[CTRL_EDRX_BIT] && doneVec[T_EDRX] |=> modeQ == ACTIVE)
        else $error("paging time did not wake the device");

    host_wake_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        modeQ == DEEP_SLEEP && supplyOk && pinEvent |=> modeQ == ACTIVE && radioEnableQ)
        else $error("pin did not wake the device");

    mode_stable_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !anyEvent |=> $stable(modeQ))
        else $error("mode changed without an event");

    psm_sleep_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
        modeQ == ACTIVE && doneVec[T_ACT] ##1 modeQ == DEEP_SLEEP);

    tau_wake_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
        modeQ == DEEP_SLEEP && doneVec[T_TAU] ##1 modeQ == ACTIVE);

    shutdown_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
        modeQ == ACTIVE && shutdownCmdQ ##1 modeQ == POWER_OFF);
endmodule : power_mode_ctrl
`default_nettype wire

// ### tb/host_pins.sv
/*
 * Host side model: pulses one of the two power pins on request.
 * Assumes req is a one-cycle pulse on sys_clk; a released pin returns low.
 */
`timescale 1ns/1ns
`default_nettype none
module host_pins #(
    parameter int HOLD = 3
) (
    // Clock
    input wire logic sys_clk,
    // Request
    input wire logic req,
    input wire logic useCtrl,
    // Pins
    output logic powerSwitchInput,
    output logic powerControlInput
);
    int holdCnt_q = 0;
    logic ctrlSel_q = 1'b0;
    // Pin held for HOLD cycles, then released
    always_ff @(posedge sys_clk) begin
        if (req) begin
            holdCnt_q <= HOLD;
            ctrlSel_q <= useCtrl;
        end else if (holdCnt_q > 0) begin
            holdCnt_q <= holdCnt_q - 1;
        end
    end
    assign powerSwitchInput = (holdCnt_q > 0) && !ctrlSel_q;
    assign powerControlInput = (holdCnt_q > 0) && ctrlSel_q;
endmodule : host_pins
`default_nettype wire

// ### tb/power_mode_state_controller_bench.sv
/*
 * Self-checking bench of the operating-mode controller.
 * Assumes the design package and a shortened real-time clock tick.
 */
`timescale 1ns/1ns
`default_nettype none
module power_mode_state_controller_bench;
    import power_mode_pkg::*;
    localparam int TICK = 4;
    localparam int INACT = INACT_TIME_S * 1000;
    localparam int LIMIT = 60000;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic supplyOk = 1'b0;
    logic hostActivity = 1'b0;
    logic gnssBusy = 1'b0;
    logic edrxGapStart = 1'b0;
    logic pinReq = 1'b0;
    logic useCtrl = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic powerSwitchInput;
    logic powerControlInput;
    logic [1:0] modeOut;
    logic ifEnable;
    logic radioEnable;
    logic rtcRun;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h1AD9;
    logic [31:0] rd;
    logic [31:0] v;
    logic err;

    power_mode_ctrl #(.RTC_TICK_CYCLES(TICK)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supplyOk(supplyOk), .powerSwitchInput(powerSwitchInput),
        .powerControlInput(powerControlInput), .hostActivity(hostActivity), .gnssBusy(gnssBusy),
        .edrxGapStart(edrxGapStart), .modeOut(modeOut), .ifEnable(ifEnable),
        .radioEnable(radioEnable), .rtcRun(rtcRun));
    host_pins host (.sys_clk(sys_clk), .req(pinReq), .useCtrl(useCtrl),
        .powerSwitchInput(powerSwitchInput), .powerControlInput(powerControlInput));

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Expected status word of a mode
    function automatic logic [31:0] status_of(input mode_e m);
        logic act;
        act = (m == ACTIVE);
        return {25'h0, m != NOT_POWERED, act, act, 2'h0, m};
    endfunction : status_of

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    // Waits up to lim cycles for mode m, then compares mode and enables
    task automatic wait_mode(input mode_e m, input int lim);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (modeOut !== m && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        check({25'h0, rtcRun, radioEnable, ifEnable, 2'h0, modeOut}, status_of(m));
        @(posedge sys_clk);
    endtask : wait_mode

    task automatic pin(input mode_e m);
        // Let the previous pulse end so that a fresh rising edge is seen
        while (powerSwitchInput || powerControlInput) begin
            @(posedge sys_clk);
        end
        v = rnd();
        pinReq <= 1'b1;
        useCtrl <= v[0];
        @(posedge sys_clk);
        pinReq <= 1'b0;
        wait_mode(m, 10);
    endtask : pin

    task automatic gap();
        edrxGapStart <= 1'b1;
        @(posedge sys_clk);
        edrxGapStart <= 1'b0;
    endtask : gap

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        wait_mode(NOT_POWERED, 0);
        apb(1'b0, CTRL_ADDR, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, 8'h20, rnd());
        check({31'h0, err}, 32'h1);
        supplyOk <= 1'b1;
        wait_mode(POWER_OFF, 5);
        apb(1'b1, CMD_ADDR, 32'h1);
        hostActivity <= 1'b1;
        @(posedge sys_clk);
        hostActivity <= 1'b0;
        gap();
        wait_mode(POWER_OFF, 0);
        for (int i = 0; i < 3; i++) begin
            v = rnd();
            apb(1'b1, T3324_ADDR + 8'(4 * i), v);
            apb(1'b0, T3324_ADDR + 8'(4 * i), 32'h0);
            check(rd, v);
        end
        apb(1'b1, STATUS_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, STATUS_ADDR, 32'h0);
        check(rd, status_of(POWER_OFF));
        apb(1'b1, CTRL_ADDR, 32'h1);
        apb(1'b1, T3324_ADDR, 32'h5);
        apb(1'b1, T3412_ADDR, 32'h14);
        apb(1'b1, EDRX_ADDR, 32'h0);
        pin(ACTIVE);
        repeat (2 * TICK) @(posedge sys_clk);
        wait_mode(ACTIVE, 0);
        wait_mode(DEEP_SLEEP, 4 * TICK + 8);
        repeat (8 * TICK) @(posedge sys_clk);
        wait_mode(DEEP_SLEEP, 0);
        wait_mode(ACTIVE, 16 * TICK + 8);
        wait_mode(DEEP_SLEEP, 6 * TICK + 8);
        pin(ACTIVE);
        apb(1'b1, CMD_ADDR, 32'h1);
        wait_mode(POWER_OFF, 5);
        pin(ACTIVE);
        pin(POWER_OFF);
        apb(1'b1, CTRL_ADDR, 32'h4);
        apb(1'b1, T3412_ADDR, 32'h0);
        apb(1'b1, EDRX_ADDR, 32'h6);
        pin(ACTIVE);
        repeat (rnd() % 16) @(posedge sys_clk);
        gap();
        wait_mode(DEEP_SLEEP, 3);
        repeat (3 * TICK) @(posedge sys_clk);
        wait_mode(DEEP_SLEEP, 0);
        wait_mode(ACTIVE, 4 * TICK + 8);
        apb(1'b1, CTRL_ADDR, 32'hC);
        gnssBusy <= 1'b1;
        gap();
        repeat (4) @(posedge sys_clk);
        wait_mode(ACTIVE, 0);
        apb(1'b1, T3324_ADDR, 32'h3);
        apb(1'b1, CTRL_ADDR, 32'h9);
        pin(POWER_OFF);
        pin(ACTIVE);
        repeat (6 * TICK) @(posedge sys_clk);
        wait_mode(ACTIVE, 0);
        gnssBusy <= 1'b0;
        wait_mode(DEEP_SLEEP, 4);
        apb(1'b1, CTRL_ADDR, 32'h2);
        pin(ACTIVE);
        repeat (INACT / 2 * TICK) @(posedge sys_clk);
        apb(1'b1, CMD_ADDR, 32'h2);
        repeat (INACT / 3 * TICK) @(posedge sys_clk);
        wait_mode(ACTIVE, 0);
        hostActivity <= 1'b1;
        @(posedge sys_clk);
        hostActivity <= 1'b0;
        repeat ((INACT - 1000) * TICK) @(posedge sys_clk);
        wait_mode(ACTIVE, 0);
        wait_mode(DEEP_SLEEP, 1000 * TICK + 20);
        supplyOk <= 1'b0;
        wait_mode(NOT_POWERED, 3);
        apb(1'b0, STATUS_ADDR, 32'h0);
        check(rd, status_of(NOT_POWERED));
        pin(NOT_POWERED);
        finish_test();
    end
endmodule : power_mode_state_controller_bench
`default_nettype wire
